/* hdl/ecm_pkg.sv */
// Package with the register map, field layout and codes of the event counter channel.
package ecm_pkg;
  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each).
  localparam logic [7:0] ECM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ECM_ADDR_COUNT = 8'h04;
  localparam logic [7:0] ECM_ADDR_STATUS = 8'h08;
  // ==========================================================================
  // Control register field positions.
  localparam int ECM_CTRL_START = 0;
  localparam int ECM_CTRL_FREE = 1;
  localparam int ECM_CTRL_DIRPIN = 2;
  localparam int ECM_CTRL_UP = 3;
  localparam int ECM_CTRL_RISE = 4;
  localparam int ECM_CTRL_PULSE = 5;
  localparam int ECM_CTRL_TRG_LO = 6;
  localparam int ECM_CTRL_TRG_HI = 7;
  // Status register field positions.
  localparam int ECM_STAT_FIRST = 0;
  localparam int ECM_STAT_OUT = 1;
  localparam int ECM_STAT_UP = 2;
  // ==========================================================================
  // Trigger select codes; the pin code enables the edge choice.
  localparam logic [1:0] ECM_TRG_PIN = 2'h0;
  localparam logic [1:0] ECM_TRG_B2 = 2'h1;
  localparam logic [1:0] ECM_TRG_PREV = 2'h2;
  localparam logic [1:0] ECM_TRG_NEXT = 2'h3;
  // ==========================================================================
  // Counter limits and reset values.
  localparam logic [15:0] ECM_CNT_MAX = 16'hffff;
  localparam logic [15:0] ECM_CNT_MIN = 16'h0000;
  localparam logic [15:0] ECM_CNT_RESET = 16'h0000;
  localparam logic [7:0] ECM_CTRL_RESET = 8'h00;
endpackage : ecm_pkg

/* hdl/ecm_timer.sv */
// Event counter mode of one 16-bit reloadable timer channel with an APB slave.
`timescale 1ns/100ps
// ============================================================================
// Function
// - Count edges on own event input pin.
// - Count wraps of preceding channel, zero uses four.
// - Count wraps of following channel or companion timer.
// - Trigger select picks pin or timer wrap source.
// - Edge choice applies only with pin code.
// - Direction chosen by software or pin level.
// - Pin low counts down, high counts up.
// - Wrap reloads reload value and keeps counting.
// - Free-run wraps without reloading.
// - Wrap period FFFFh-n+1 up, n+1 down.
// - Start bit one counts, zero stops.
// - Interrupt request on every overflow or underflow.
// - Count register read returns current counter.
// - Write before first event loads reload and counter.
// - Write after first event loads reload only.
// - Pulse output toggles pin at every wrap.
// - Pulse output drives pin low while stopped.
// - Two-phase counting, meant for channels two to four, is not built.
module ecm_timer #(
  parameter int CHANNEL_INDEX = 0 // Position in the ring of five channels.
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic event_input_pin_i,
  input wire logic timer_output_pin_i,
  output logic timer_output_pin_o,
  output logic timer_output_pin_oe_o,
  input wire logic prev_wrap_i,
  input wire logic next_wrap_i,
  input wire logic b2_wrap_i,
  output logic wrap_o,
  output logic irq_o
);
  import ecm_pkg::*;

  // Two-phase counting is not built here, so any ring position is served.
  // Positions two to four would carry it; this channel counts single events
  // only, which keeps all five positions alike at the cost of that mode.
  if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 4) begin : g_bad_index
    $error("CHANNEL_INDEX must lie between 0 and 4.");
  end

  // ==========================================================================
  // Pin synchronisers.
  logic ev_s1; // First stage, read only by ev_s2.
  logic ev_s2; // Settled event pin level.
  logic ev_s3; // Previous settled level for edge detection.
  logic dir_s1; // First stage, read only by dir_s2.
  logic dir_s2; // Settled direction pin level.

  // Both pins are asynchronous to clk_i, hence two flops before any logic.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
    end else begin
      ev_s1 <= event_input_pin_i;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      dir_s1 <= timer_output_pin_i;
      dir_s2 <= dir_s1;
    end
  end

  // ==========================================================================
  // Control state.
  logic start; // Channel start bit.
  logic free_run; // Wrap without reload when set.
  logic dir_pin; // Direction taken from the output pin when set.
  logic dir_up_sw; // Software direction, one counts up.
  logic edge_rise; // Pin edge choice, one is rising.
  logic pulse_en; // Pulse output on the output pin.
  logic [1:0] trg_sel; // Trigger select field.
  logic [15:0] reload; // Reload register.
  logic [15:0] cnt; // Counter.
  logic first_seen; // First event taken since start.
  logic out_lvl; // Pulse output level.
  logic next_start;
  logic next_free_run;
  logic next_dir_pin;
  logic next_dir_up_sw;
  logic next_edge_rise;
  logic next_pulse_en;
  logic [1:0] next_trg_sel;
  logic [15:0] next_reload;
  logic [15:0] next_cnt;
  logic next_first_seen;
  logic next_out_lvl;
  logic next_wrap;

  // ==========================================================================
  // APB slave signals.
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic acc_done; // Access completes at this edge.
  logic wr_ctrl; // Write to the control register.
  logic wr_count; // Write to the count register.
  logic addr_ok; // Address maps to a register.

  // ==========================================================================
  // Event selection and direction.
  logic pin_edge; // Chosen edge on the settled event pin.
  logic ev_raw; // Event from the selected source.
  logic step; // One count step this cycle.
  logic dir_up; // Effective direction.
  logic at_limit; // Counter at the wrap limit.
  logic wrap_now; // Overflow or underflow this cycle.

  // The edge choice matters only for the pin code; wraps are already pulses.
  always_comb begin
    pin_edge = edge_rise ? (ev_s2 & ~ev_s3) : (~ev_s2 & ev_s3);
    unique case (trg_sel)
      ECM_TRG_PIN: ev_raw = pin_edge;
      ECM_TRG_B2: ev_raw = b2_wrap_i;
      ECM_TRG_PREV: ev_raw = prev_wrap_i;
      ECM_TRG_NEXT: ev_raw = next_wrap_i;
    endcase
    step = start & ev_raw;
    dir_up = dir_pin ? dir_s2 : dir_up_sw;
    at_limit = dir_up ? (cnt == ECM_CNT_MAX) : (cnt == ECM_CNT_MIN);
    wrap_now = step & at_limit;
  end

  // ==========================================================================
  // APB decode.
  // Zero wait would need combinational read data; one wait state keeps
  // every output straight from a flop.
  always_comb begin
    acc_done = psel_i & penable_i & pready_o;
    addr_ok = (paddr_i == ECM_ADDR_CTRL) | (paddr_i == ECM_ADDR_COUNT)
            | (paddr_i == ECM_ADDR_STATUS);
    wr_ctrl = acc_done & pwrite_i & (paddr_i == ECM_ADDR_CTRL);
    wr_count = acc_done & pwrite_i & (paddr_i == ECM_ADDR_COUNT);
    next_pready = psel_i & penable_i & ~pready_o;
    next_pslverr = psel_i & penable_i & ~pready_o & ~addr_ok;
    next_prdata = 32'h0000_0000;
    if (psel_i && penable_i && !pready_o && !pwrite_i) begin
      if (paddr_i == ECM_ADDR_CTRL) begin
        next_prdata[ECM_CTRL_START] = start;
        next_prdata[ECM_CTRL_FREE] = free_run;
        next_prdata[ECM_CTRL_DIRPIN] = dir_pin;
        next_prdata[ECM_CTRL_UP] = dir_up_sw;
        next_prdata[ECM_CTRL_RISE] = edge_rise;
        next_prdata[ECM_CTRL_PULSE] = pulse_en;
        next_prdata[ECM_CTRL_TRG_HI:ECM_CTRL_TRG_LO] = trg_sel;
      end else if (paddr_i == ECM_ADDR_COUNT) begin
        next_prdata[15:0] = cnt;
      end else if (paddr_i == ECM_ADDR_STATUS) begin
        next_prdata[ECM_STAT_FIRST] = first_seen;
        next_prdata[ECM_STAT_OUT] = out_lvl;
        next_prdata[ECM_STAT_UP] = dir_up;
      end
    end
  end

  // ==========================================================================
  // Next control and counter state.
  always_comb begin
    next_start = start;
    next_free_run = free_run;
    next_dir_pin = dir_pin;
    next_dir_up_sw = dir_up_sw;
    next_edge_rise = edge_rise;
    next_pulse_en = pulse_en;
    next_trg_sel = trg_sel;
    next_reload = reload;
    next_cnt = cnt;
    next_first_seen = first_seen;
    next_out_lvl = out_lvl;
    next_wrap = wrap_now;
    if (wr_ctrl) begin
      next_start = pwdata_i[ECM_CTRL_START];
      next_free_run = pwdata_i[ECM_CTRL_FREE];
      next_dir_pin = pwdata_i[ECM_CTRL_DIRPIN];
      next_dir_up_sw = pwdata_i[ECM_CTRL_UP];
      next_edge_rise = pwdata_i[ECM_CTRL_RISE];
      next_pulse_en = pwdata_i[ECM_CTRL_PULSE];
      next_trg_sel = pwdata_i[ECM_CTRL_TRG_HI:ECM_CTRL_TRG_LO];
    end
    // Counting steps first; a count write may then override the counter.
    if (step) begin
      next_first_seen = 1'b1;
      if (wrap_now) begin
        if (free_run) begin
          next_cnt = dir_up ? ECM_CNT_MIN : ECM_CNT_MAX;
        end else begin
          next_cnt = reload;
        end
      end else begin
        next_cnt = dir_up ? cnt + 16'h0001 : cnt - 16'h0001;
      end
    end
    if (wr_count) begin
      next_reload = pwdata_i[15:0];
      // Before the first event the write also lands in the counter.
      if (!start || !first_seen) begin
        next_cnt = pwdata_i[15:0];
      end
    end
    // A stopped channel forgets its first event, so a restart loads again.
    if (!start) begin
      next_first_seen = 1'b0;
    end
    // Pulse output: low while stopped, inverted at every wrap.
    if (!start) begin
      next_out_lvl = 1'b0;
    end else if (wrap_now && pulse_en) begin
      next_out_lvl = ~out_lvl;
    end
  end

  // ==========================================================================
  // State registers.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      start <= ECM_CTRL_RESET[ECM_CTRL_START];
      free_run <= ECM_CTRL_RESET[ECM_CTRL_FREE];
      dir_pin <= ECM_CTRL_RESET[ECM_CTRL_DIRPIN];
      dir_up_sw <= ECM_CTRL_RESET[ECM_CTRL_UP];
      edge_rise <= ECM_CTRL_RESET[ECM_CTRL_RISE];
      pulse_en <= ECM_CTRL_RESET[ECM_CTRL_PULSE];
      trg_sel <= ECM_CTRL_RESET[ECM_CTRL_TRG_HI:ECM_CTRL_TRG_LO];
      reload <= ECM_CNT_RESET;
      cnt <= ECM_CNT_RESET;
      first_seen <= 1'b0;
      out_lvl <= 1'b0;
    end else begin
      start <= next_start;
      free_run <= next_free_run;
      dir_pin <= next_dir_pin;
      dir_up_sw <= next_dir_up_sw;
      edge_rise <= next_edge_rise;
      pulse_en <= next_pulse_en;
      trg_sel <= next_trg_sel;
      reload <= next_reload;
      cnt <= next_cnt;
      first_seen <= next_first_seen;
      out_lvl <= next_out_lvl;
    end
  end

  // ==========================================================================
  // Output registers.
  // The pin is released whenever it serves as the direction input.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      timer_output_pin_o <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
      wrap_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      timer_output_pin_o <= next_out_lvl;
      timer_output_pin_oe_o <= next_pulse_en & ~next_dir_pin;
      wrap_o <= next_wrap;
      irq_o <= next_wrap;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_WRAP_IRQ: assert property (wrap_now |=> irq_o && wrap_o)
    else $error("Wrap did not raise the request.");
  AST_RELOAD: assert property (wrap_now && !free_run && !wr_count |=>
    cnt == $past(reload))
    else $error("Counter did not reload on wrap.");
  AST_FREE_DOWN: assert property (wrap_now && free_run && !dir_up && !wr_count |=>
    cnt == ECM_CNT_MAX)
    else $error("Free-run underflow did not wrap to all ones.");
  AST_STEP_UP: assert property (step && dir_up && !at_limit && !wr_count |=>
    cnt == $past(cnt) + 16'h0001)
    else $error("Up count step wrong.");
  AST_STOPPED: assert property (!start && !wr_count |=> $stable(cnt))
    else $error("Counter moved while stopped.");
  AST_WR_BOTH: assert property (wr_count && !first_seen |=>
    cnt == $past(pwdata_i[15:0]) && reload == $past(pwdata_i[15:0]))
    else $error("Early write did not load both.");
  AST_WR_RELOAD: assert property (wr_count && start && first_seen && !step |=>
    cnt == $past(cnt))
    else $error("Late write changed the counter.");
  AST_OUT_LOW: assert property (!start ##1 !start |=> !timer_output_pin_o)
    else $error("Output not low while stopped.");
  AST_TOGGLE: assert property (wrap_now && pulse_en && start && !wr_ctrl |=>
    timer_output_pin_o != $past(timer_output_pin_o))
    else $error("Output did not toggle on wrap.");
  AST_PIN_EDGE: assert property (start && trg_sel == ECM_TRG_PIN && edge_rise
    && ev_s2 && !ev_s3 |-> step)
    else $error("Rising pin edge not counted.");
  AST_DIR_PIN: assert property (dir_pin && !dir_s2 |-> !dir_up)
    else $error("Low direction pin did not count down.");
  AST_APB_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Slave did not answer after one wait.");
  // Guards for the paths that the checks above leave open.
  AST_STEP_DOWN: assert property (step && !dir_up && !at_limit && !wr_count |=>
    cnt == $past(cnt) - 16'h0001)
    else $error("Down count step wrong.");
  AST_FREE_UP: assert property (wrap_now && free_run && dir_up && !wr_count |=>
    cnt == ECM_CNT_MIN)
    else $error("Free-run overflow did not wrap to zero.");
  AST_PIN_FALL: assert property (start && trg_sel == ECM_TRG_PIN && !edge_rise
    && !ev_s2 && ev_s3 |-> step)
    else $error("Falling pin edge not counted.");
  AST_OE_DIRPIN: assert property (dir_pin && !wr_ctrl |=> !timer_output_pin_oe_o)
    else $error("Output pin driven while it selects the direction.");
  AST_NO_IRQ_STOPPED: assert property (!start |=> !irq_o)
    else $error("Request raised while stopped.");
  AST_APB_ERR: assert property (psel_i && penable_i && !pready_o && !addr_ok |=>
    pslverr_o)
    else $error("Unmapped address did not answer with an error.");

  COV_RELOAD_WRAP: cover property (wrap_now && !free_run);
  COV_FREE_WRAP: cover property (wrap_now && free_run && dir_up);
  COV_LATE_WRITE: cover property (wr_count && first_seen && start);
  COV_NEIGHBOUR: cover property (step && trg_sel == ECM_TRG_PREV);
  COV_PIN_RISE: cover property (step && trg_sel == ECM_TRG_PIN && edge_rise);

endmodule : ecm_timer

/* bench/ecm_partner.sv */
// Far-side model: event pin source, neighbour wrap pulses and direction pin level.
`timescale 1ns/100ps
module ecm_partner (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic fire_i, // One event request, one cycle wide.
  input wire logic [1:0] src_i, // Trigger code that says where the event comes from.
  input wire logic dir_up_i, // Direction level the pin should show.
  output logic event_pin_o,
  output logic dir_pin_o,
  output logic prev_wrap_o,
  output logic next_wrap_o,
  output logic b2_wrap_o
);
  import ecm_pkg::*;
  // ==========================================================================
  // Event generation
  // Wrap pulses last one cycle, as a neighbour channel gives them.
  // The pin toggles once per request; the bench spaces requests so each level holds.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      event_pin_o <= 1'b0;
      dir_pin_o <= 1'b0;
      prev_wrap_o <= 1'b0;
      next_wrap_o <= 1'b0;
      b2_wrap_o <= 1'b0;
    end else begin
      prev_wrap_o <= fire_i && (src_i == ECM_TRG_PREV);
      next_wrap_o <= fire_i && (src_i == ECM_TRG_NEXT);
      b2_wrap_o <= fire_i && (src_i == ECM_TRG_B2);
      if (fire_i && (src_i == ECM_TRG_PIN)) begin
        event_pin_o <= !event_pin_o;
      end
      dir_pin_o <= dir_up_i;
    end
  end
endmodule : ecm_partner

/* bench/event_counter_mode_timer_bench.sv */
// Self-checking bench for the event counter channel.
`timescale 1ns/100ps
module event_counter_mode_timer_bench;
  import ecm_pkg::*;
  // ==========================================================================
  // Signals
  logic clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, out_o, oe_o, wrap_o, irq_o, pin_wire;
  logic ev_pin, dir_pin, prev_w, next_w, b2_w;
  logic fire_i = 1'b0, dir_up_i = 1'b0;
  logic [1:0] src_i = 2'h0;
  int err_total = 0, n_checks = 0, wraps = 0, irqs = 0;
  // One ordinary case: control word, direction level, load, events and results.
  typedef struct {logic [7:0] ctrl; logic dir; logic [15:0] n; int ev;
    logic [15:0] cnt; int wr; logic out;} ecm_row_t;
  ecm_row_t rows [9] = '{
    '{8'ha1, 1'b0, 16'h0003, 5, 16'h0002, 1, 1'b1},
    '{8'he9, 1'b0, 16'hfffd, 4, 16'hfffe, 1, 1'b1},
    '{8'h4b, 1'b0, 16'hfffe, 3, 16'h0001, 1, 1'b0},
    '{8'h01, 1'b0, 16'h0002, 3, 16'h0001, 0, 1'b0},
    '{8'h11, 1'b0, 16'h0002, 1, 16'h0002, 0, 1'b0},
    '{8'h11, 1'b0, 16'h0002, 2, 16'h0001, 0, 1'b0},
    '{8'h85, 1'b0, 16'h0001, 2, 16'h0001, 1, 1'b0},
    '{8'h85, 1'b1, 16'hfffe, 2, 16'hfffe, 1, 1'b0},
    '{8'h43, 1'b0, 16'h0001, 3, 16'hfffe, 1, 1'b0}};
  // The shared pin reads the design while it drives, else the partner's level.
  assign pin_wire = oe_o ? out_o : dir_pin;
  always #5 clk_i = ~clk_i;
  // ==========================================================================
  // Instances
  ecm_timer dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .event_input_pin_i(ev_pin), .timer_output_pin_i(pin_wire), .timer_output_pin_o(out_o),
    .timer_output_pin_oe_o(oe_o), .prev_wrap_i(prev_w), .next_wrap_i(next_w),
    .b2_wrap_i(b2_w), .wrap_o(wrap_o), .irq_o(irq_o));
  ecm_partner far (.clk_i(clk_i), .reset_n_i(reset_n_i), .fire_i(fire_i), .src_i(src_i),
    .dir_up_i(dir_up_i), .event_pin_o(ev_pin), .dir_pin_o(dir_pin), .prev_wrap_o(prev_w),
    .next_wrap_o(next_w), .b2_wrap_o(b2_w));
  // Counts wrap and interrupt pulses; each stands one cycle only.
  always @(posedge clk_i) begin
    if (wrap_o === 1'b1) wraps++;
    if (irq_o === 1'b1) irqs++;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang.
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd
  // Events are spaced wide so a pin level holds well past the synchroniser.
  task automatic ev(input int k);
    repeat (k) begin
      @(posedge clk_i);
      fire_i <= 1'b1;
      @(posedge clk_i);
      fire_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask : ev
  task results;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // ==========================================================================
  // Watchdog: the whole run needs far fewer cycles than this.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(ECM_ADDR_CTRL, 32'h0);
    rd(ECM_ADDR_COUNT, 32'h0);
    chk(oe_o, 1'b0);
    foreach (rows[i]) begin
      dir_up_i <= rows[i].dir;
      src_i <= rows[i].ctrl[7:6];
      wr(ECM_ADDR_CTRL, 32'h0);
      wr(ECM_ADDR_COUNT, rows[i].n);
      wr(ECM_ADDR_CTRL, rows[i].ctrl);
      wraps = 0;
      irqs = 0;
      ev(rows[i].ev);
      rd(ECM_ADDR_COUNT, rows[i].cnt);
      chk(wraps, rows[i].wr);
      chk(irqs, rows[i].wr);
      chk(out_o, rows[i].out);
    end
    // A write after the first event only reaches the reload value.
    src_i <= ECM_TRG_PREV;
    wr(ECM_ADDR_CTRL, 32'h0);
    wr(ECM_ADDR_COUNT, 32'h5);
    wr(ECM_ADDR_CTRL, 32'h81);
    ev(1);
    wr(ECM_ADDR_COUNT, 32'h9);
    rd(ECM_ADDR_COUNT, 32'h4);
    rd(ECM_ADDR_STATUS, 32'h1);
    ev(5);
    rd(ECM_ADDR_COUNT, 32'h9);
    // Restart, then write before any event: the counter follows.
    wr(ECM_ADDR_CTRL, 32'h0);
    wr(ECM_ADDR_CTRL, 32'h81);
    wr(ECM_ADDR_COUNT, 32'h7);
    rd(ECM_ADDR_COUNT, 32'h7);
    // Stopped with pulse output on: events ignored and pin low.
    wr(ECM_ADDR_CTRL, 32'ha0);
    ev(2);
    rd(ECM_ADDR_COUNT, 32'h7);
    chk(out_o, 1'b0);
    chk(oe_o, 1'b1);
    // Unmapped address answers with an error and zero data.
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk(q, 32'h0);
    chk(e, 1'b1);
    results();
  end
endmodule : event_counter_mode_timer_bench
